// *** hdl/bsf_pkg.sv ***
// Behaviour
// (R1) slave two-wire: mid-frame stop sets early flag
// (R2) early flag cleared by 0 after read 1
// (R3) slave two-wire: end-of-frame stop sets normal flag
// (R4) normal flag cleared by 0 after read 1
// (R5) main flag clear also clears both stop flags
// (R6) stop flags act only in slave two-wire
// (R7) main flag set together with transfer request
// (R8) slave: empty/full rise with second match sets request; the code sets it only as slave in two-wire format
// (R9) master: empty/full rise sets request
// (R10) request flag cleared by 0 after read 1
// (R11) main flag clear with enable 0 clears request
// (R12) early flag resets to 0
// (R13) normal flag resets to 0
// (R14) request flag resets to 0, write 0 only
// (R15) second match flag reports second address hit
// (R16) never both stop flags set at once
// (R17) writing 1 or unarmed 0 changes nothing
package bsf_pkg;
  localparam logic [1:0] STATUS_OFS   = 2'h0;
  localparam logic [1:0] CTRL_OFS     = 2'h1;
  localparam int         EARLY_BIT    = 7;
  localparam int         NORMAL_BIT   = 6;
  localparam int         CONT_BIT     = 5;
  localparam int         MATCH2_BIT   = 4;
  localparam int         ICE_BIT      = 7;
  localparam int         MASTER_BIT   = 6;
  localparam int         TWO_WIRE_BIT = 5;
  localparam int         MAIN_BIT     = 0;
  localparam int         FL_EARLY     = 0;
  localparam int         FL_NORMAL    = 1;
  localparam int         FL_CONT      = 2;
  localparam int         FL_MAIN      = 3;
  localparam int         NUM_FLAGS    = 4;
  localparam logic [3:0] FLAGS_RESET  = 4'h0;
  localparam logic [7:0] RDATA_IDLE   = 8'h00;
  localparam logic [3:0] FRAME_BITS   = 4'h9;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE  = 4'h1;

  typedef struct packed {
    logic interface_enable_bit;
    logic master;
    logic two_wire;
  } bsf_mode_t;

  typedef struct packed {
    logic start_seen;
    logic stop_seen;
    logic mid_frame;
  } bsf_bus_ev_t;
endpackage

// *** hdl/bsf_bus_watch.sv ***
`timescale 1ns/1ps
module bsf_bus_watch (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output bsf_pkg::bsf_bus_ev_t ev
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;
  logic [3:0] bit_cnt;

  localparam logic [3:0] FRAME_BITS   = bsf_pkg::FRAME_BITS;
  localparam logic [3:0] BIT_CNT_ZERO = bsf_pkg::BIT_CNT_ZERO;
  localparam logic [3:0] BIT_CNT_ONE  = bsf_pkg::BIT_CNT_ONE;

  // second stage only feeds the edge logic; first stage is never read elsewhere
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  wire scl_now  = scl_sync[1];
  wire sda_now  = sda_sync[1];
  wire scl_rise = scl_now & ~scl_d;
  wire start_hit = scl_now & scl_d & sda_d & ~sda_now;
  wire stop_hit  = scl_now & scl_d & ~sda_d & sda_now;
  wire frame_end = scl_rise & (bit_cnt == (FRAME_BITS - BIT_CNT_ONE));
  wire [3:0] next_bit_cnt = start_hit | stop_hit | frame_end ? BIT_CNT_ZERO :
                            scl_rise ? bit_cnt + BIT_CNT_ONE : bit_cnt;

  // the stop's own clock rise is counted too, so only more than one rise is mid-frame
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bit_cnt <= bsf_pkg::BIT_CNT_ZERO;
      ev      <= '0;
    end else begin
      bit_cnt       <= next_bit_cnt;
      ev.start_seen <= start_hit;
      ev.stop_seen  <= stop_hit;
      ev.mid_frame  <= bit_cnt > bsf_pkg::BIT_CNT_ONE;
    end
  end
endmodule

// *** hdl/bsf_status_flags.sv ***
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module bsf_status_flags (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       transmit_empty_flag,
  input  wire logic       receive_full_flag,
  input  wire logic       second_address_match_flag,
  input  wire logic       main_set_other,
  output logic            early_end_condition_flag,
  output logic            normal_end_flag,
  output logic            continuous_transfer_request_flag,
  output logic            main_interrupt_flag
);
  bsf_pkg::bsf_mode_t   mode;
  bsf_pkg::bsf_bus_ev_t ev;
  logic [3:0]           flag;
  logic [3:0]           armed;
  logic                 te_d;
  logic                 rf_d;

  bsf_bus_watch u_watch (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ev     (ev)
  );

  wire sel_status = addr == bsf_pkg::STATUS_OFS;
  wire sel_ctrl   = addr == bsf_pkg::CTRL_OFS;
  wire wr_status  = wr & sel_status;
  wire wr_ctrl    = wr & sel_ctrl;
  wire rd_status  = rd & sel_status;
  wire rd_ctrl    = rd & sel_ctrl;

  // stop flags mean something only as slave in two-wire format
  wire slave_i2c  = ~mode.master & mode.two_wire; // see (R6)
  wire data_event = (transmit_empty_flag & ~te_d) | (receive_full_flag & ~rf_d);

  wire [3:0] set_ev;
  wire [3:0] hw_clr;
  wire [3:0] sw_zero;
  wire [3:0] rd_hit;
  wire [3:0] sw_clr;
  wire       main_drop;

  assign set_ev[bsf_pkg::FL_EARLY]  = ev.stop_seen & slave_i2c & ev.mid_frame; // see (R1)
  assign set_ev[bsf_pkg::FL_NORMAL] = ev.stop_seen & slave_i2c & ~ev.mid_frame; // see (R3)
  assign set_ev[bsf_pkg::FL_CONT]   = data_event &
                                      ((slave_i2c & second_address_match_flag) | // see (R8)
                                       mode.master); // see (R9)
  assign set_ev[bsf_pkg::FL_MAIN]   = set_ev[bsf_pkg::FL_CONT] | main_set_other; // see (R7)

  // only a 0 in the bit position asks for a clear; a 1 is ignored
  assign sw_zero[bsf_pkg::FL_EARLY]  = wr_status & ~wdata[bsf_pkg::EARLY_BIT]; // see (R17)
  assign sw_zero[bsf_pkg::FL_NORMAL] = wr_status & ~wdata[bsf_pkg::NORMAL_BIT]; // see (R17)
  assign sw_zero[bsf_pkg::FL_CONT]   = wr_status & ~wdata[bsf_pkg::CONT_BIT]; // see (R14)
  assign sw_zero[bsf_pkg::FL_MAIN]   = wr_ctrl & ~wdata[bsf_pkg::MAIN_BIT];

  assign rd_hit[bsf_pkg::FL_EARLY]  = rd_status;
  assign rd_hit[bsf_pkg::FL_NORMAL] = rd_status;
  assign rd_hit[bsf_pkg::FL_CONT]   = rd_status;
  assign rd_hit[bsf_pkg::FL_MAIN]   = rd_ctrl;

  // a zero write clears only a flag that software has seen as 1
  assign sw_clr = sw_zero & armed; // see (R2) see (R4) see (R10)

  assign main_drop = flag[bsf_pkg::FL_MAIN] & sw_clr[bsf_pkg::FL_MAIN] &
                     ~set_ev[bsf_pkg::FL_MAIN];

  // whichever stop flag is set pushes the other to 0
  assign hw_clr[bsf_pkg::FL_EARLY]  = main_drop | set_ev[bsf_pkg::FL_NORMAL]; // see (R5) see (R16)
  assign hw_clr[bsf_pkg::FL_NORMAL] = main_drop | set_ev[bsf_pkg::FL_EARLY]; // see (R5) see (R16)
  assign hw_clr[bsf_pkg::FL_CONT]   = main_drop & ~mode.interface_enable_bit; // see (R11)
  assign hw_clr[bsf_pkg::FL_MAIN]   = 1'b0;

  genvar k;
  generate
    for (k = 0; k < bsf_pkg::NUM_FLAGS; k++) begin : g_flag
      // set beats any clear in the same cycle so no event is lost
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          flag[k]  <= bsf_pkg::FLAGS_RESET[k]; // see (R12) see (R13) see (R14)
          armed[k] <= 1'b0;
        end else begin
          flag[k]  <= set_ev[k] | (flag[k] & ~sw_clr[k] & ~hw_clr[k]);
          armed[k] <= (rd_hit[k] & flag[k]) |
                      (armed[k] & flag[k] & ~sw_zero[k] & ~hw_clr[k]);
        end
      end
    end
  endgenerate

  wire [7:0] status_view = {flag[bsf_pkg::FL_EARLY], flag[bsf_pkg::FL_NORMAL],
                            flag[bsf_pkg::FL_CONT], second_address_match_flag, // see (R15)
                            4'h0};
  wire [7:0] ctrl_view   = {mode.interface_enable_bit, mode.master, mode.two_wire, 4'h0,
                            flag[bsf_pkg::FL_MAIN]};
  wire [7:0] next_rdata  = rd_status ? status_view :
                           rd_ctrl   ? ctrl_view   : bsf_pkg::RDATA_IDLE;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode  <= '0;
      te_d  <= 1'b0;
      rf_d  <= 1'b0;
      rdata <= bsf_pkg::RDATA_IDLE;
    end else begin
      te_d  <= transmit_empty_flag;
      rf_d  <= receive_full_flag;
      rdata <= next_rdata;
      if (wr_ctrl) begin
        mode.interface_enable_bit      <= wdata[bsf_pkg::ICE_BIT];
        mode.master   <= wdata[bsf_pkg::MASTER_BIT];
        mode.two_wire <= wdata[bsf_pkg::TWO_WIRE_BIT];
      end
    end
  end

  assign early_end_condition_flag         = flag[bsf_pkg::FL_EARLY];
  assign normal_end_flag                  = flag[bsf_pkg::FL_NORMAL];
  assign continuous_transfer_request_flag = flag[bsf_pkg::FL_CONT];
  assign main_interrupt_flag              = flag[bsf_pkg::FL_MAIN];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence early_read_one;
    rd_status && flag[bsf_pkg::FL_EARLY];
  endsequence
  sequence early_write_zero;
    wr_status && !wdata[bsf_pkg::EARLY_BIT] && armed[bsf_pkg::FL_EARLY] &&
    !set_ev[bsf_pkg::FL_EARLY];
  endsequence
  sequence cont_read_one;
    rd_status && flag[bsf_pkg::FL_CONT];
  endsequence
  sequence cont_write_zero;
    wr_status && !wdata[bsf_pkg::CONT_BIT] && armed[bsf_pkg::FL_CONT] &&
    !set_ev[bsf_pkg::FL_CONT];
  endsequence

  early_set_a: assert property ( // see (R1)
    ev.stop_seen && slave_i2c && ev.mid_frame |=> early_end_condition_flag && !normal_end_flag)
    else $error("mid-frame stop did not raise early flag");

  normal_set_a: assert property ( // see (R3)
    ev.stop_seen && slave_i2c && !ev.mid_frame |=> normal_end_flag && !early_end_condition_flag)
    else $error("end-of-frame stop did not raise normal flag");

  stop_excl_a: assert property ( // see (R16)
    !(early_end_condition_flag && normal_end_flag))
    else $error("both stop flags set");

  stop_gate_a: assert property ( // see (R6)
    !slave_i2c && !early_end_condition_flag && !main_drop |=> !early_end_condition_flag)
    else $error("early flag set outside slave two-wire");

  main_with_req_a: assert property ( // see (R7)
    set_ev[bsf_pkg::FL_CONT] |=> continuous_transfer_request_flag && main_interrupt_flag)
    else $error("main flag not set with request flag");

  req_slave_a: assert property ( // see (R8)
    slave_i2c && second_address_match_flag && $rose(receive_full_flag)
    |-> ##1 continuous_transfer_request_flag)
    else $error("slave request not set on full with second match");

  req_master_a: assert property ( // see (R9)
    mode.master && $rose(transmit_empty_flag) |=> continuous_transfer_request_flag)
    else $error("master request not set on empty");

  early_arm_a: assert property ( // see (R2)
    early_read_one |=> armed[bsf_pkg::FL_EARLY] || !early_end_condition_flag)
    else $error("read of early flag did not arm it");

  early_clear_a: assert property ( // see (R2)
    early_write_zero |=> !early_end_condition_flag)
    else $error("early flag not cleared by read-1 then write-0");

  cont_arm_a: assert property ( // see (R10)
    cont_read_one |=> armed[bsf_pkg::FL_CONT] || !continuous_transfer_request_flag)
    else $error("read of request flag did not arm it");

  req_clear_a: assert property ( // see (R10)
    cont_write_zero |=> !continuous_transfer_request_flag)
    else $error("request flag not cleared by read-1 then write-0");

  one_write_a: assert property ( // see (R17)
    wr_status && !continuous_transfer_request_flag && !set_ev[bsf_pkg::FL_CONT]
    |=> !continuous_transfer_request_flag)
    else $error("write set the request flag");

  unarmed_zero_a: assert property ( // see (R17)
    wr_status && normal_end_flag && !armed[bsf_pkg::FL_NORMAL] && !main_drop
    && !set_ev[bsf_pkg::FL_EARLY] |=> normal_end_flag)
    else $error("unarmed zero write cleared normal flag");

  main_clear_a: assert property ( // see (R5)
    main_drop && !set_ev[bsf_pkg::FL_NORMAL] |=> !normal_end_flag ##1 !main_interrupt_flag
    or !normal_end_flag)
    else $error("main clear left normal flag set");

  ice_clear_a: assert property ( // see (R11)
    main_drop && !mode.interface_enable_bit && !set_ev[bsf_pkg::FL_CONT] |=> !continuous_transfer_request_flag)
    else $error("main clear with enable 0 left request set");

  reset_flags_a: assert property (disable iff (1'b0) // see (R12) see (R13) see (R14)
    !rst_n |=> !early_end_condition_flag && !normal_end_flag && !continuous_transfer_request_flag)
    else $error("flags not zero after reset");

  read_match_a: assert property ( // see (R15)
    rd_status |=> rdata[bsf_pkg::MATCH2_BIT] == $past(second_address_match_flag))
    else $error("second match flag not reported");
endmodule

// *** testbench/bsf_bus_host.sv ***
`timescale 1ns/1ps
module bsf_bus_host (
  output logic scl,
  output logic sda
);
  // idle lines are driven high by the host itself; link clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start, n clock pulses of 64 ns, then stop; data only moves while the clock is low
  task automatic frame(input int n);
    sda = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      scl = 1'b0;
      #16 sda = i[0];
      #16 scl = 1'b1;
      #32;
    end
    scl = 1'b0;
    #16 sda = 1'b0;
    #16 scl = 1'b1;
    #32 sda = 1'b1;
    #64;
  endtask
endmodule

// *** testbench/test_bsf_status_flags.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
module test_bsf_status_flags;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        tx_e = 1'b0;
  logic        rx_f = 1'b0;
  logic        match2 = 1'b0;
  logic        main_set = 1'b0;
  logic [7:0]  rdata;
  logic        scl, sda, early, normal, req, main;
  logic [15:0] rnd = 16'h1BE2;
  logic [7:0]  ctl = 8'h00;
  bit          me, mn, mr, mm, ae, an, ar, am;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #4 mclk = ~mclk;

  bsf_bus_host i_bsf_bus_host (.scl(scl), .sda(sda));
  bsf_status_flags i_bsf_status_flags (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .sda_in(sda),
    .transmit_empty_flag(tx_e), .receive_full_flag(rx_f),
    .second_address_match_flag(match2), .main_set_other(main_set),
    .early_end_condition_flag(early), .normal_end_flag(normal),
    .continuous_transfer_request_flag(req), .main_interrupt_flag(main));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // a read arms the flags it saw set
  task automatic rd_reg(input logic [1:0] a);
    logic [7:0] exp;
    exp = (a == 2'h0) ? {me, mn, mr, match2, 4'h0} :
          (a == 2'h1) ? {ctl[7:5], 4'h0, mm} : 8'h00;
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 `CHK(rdata, exp)
    `CHK({early, normal, req, main}, {me, mn, mr, mm})
    if (a == 2'h0) {ae, an, ar} = {me, mn, mr};
    if (a == 2'h1) am = mm;
  endtask

  // ones and unarmed zeros leave flags alone; any zero disarms
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    if (a == 2'h0) begin
      if (!d[7] && ae) me = 1'b0;
      if (!d[6] && an) mn = 1'b0;
      if (!d[5] && ar) mr = 1'b0;
      {ae, an, ar} = {ae, an, ar} & d[7:5];
    end
    if (a == 2'h1) begin
      ctl = d & 8'hE0;
      if (!d[0] && am) begin
        {mm, me, mn} = 3'h0;
        if (!ctl[7]) mr = 1'b0;
      end
      am = am & d[0];
    end
  endtask

  // request and main flag must be visible two cycles after the rise
  task automatic event_rise(input bit f, input bit m);
    @(posedge mclk);
    tx_e <= !f;
    rx_f <= f;
    match2 <= m;
    @(posedge mclk);
    @(posedge mclk);
    if (ctl[6] || (ctl[5] && m)) {mr, mm} = 2'h3;
    #1 `CHK({req, main}, {mr, mm})
    @(posedge mclk);
    tx_e <= 1'b0;
    rx_f <= 1'b0;
  endtask

  // bounded wait for a stop flag; exactly one of the pair may rise
  task automatic wait_stop(input bit set, input bit erl);
    int i;
    for (i = 0; i < 16 && !(early || normal); i++) @(posedge mclk);
    `CHK(early | normal, set)
    // a stop sets one flag and forces the other, and its arm, to 0
    if (set) begin
      {me, mn} = {erl, !erl};
      {ae, an} = {ae & erl, an & !erl};
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(2'h0);
    rd_reg(2'h1);
    rnd = lfsr(rnd);
    wr_reg(2'h3, rnd[7:0]);
    rd_reg(2'h3);
    wr_reg(2'h1, 8'hA0);
    i_bsf_bus_host.frame(3);
    wait_stop(1'b1, 1'b1);
    rd_reg(2'h0);
    rnd = lfsr(rnd);
    wr_reg(2'h0, rnd[7:0] | 8'hE0);
    rd_reg(2'h0);
    wr_reg(2'h0, 8'h00);
    rd_reg(2'h0);
    i_bsf_bus_host.frame(9);
    wait_stop(1'b1, 1'b0);
    wr_reg(2'h0, 8'h00);
    rd_reg(2'h0);
    wr_reg(2'h0, 8'h00);
    rd_reg(2'h0);
    i_bsf_bus_host.frame(9);
    wait_stop(1'b1, 1'b0);
    @(posedge mclk);
    main_set <= 1'b1;
    @(posedge mclk);
    main_set <= 1'b0;
    mm = 1'b1;
    rd_reg(2'h1);
    wr_reg(2'h1, 8'hA0);
    rd_reg(2'h0);
    wr_reg(2'h1, 8'hE0);
    i_bsf_bus_host.frame(3);
    wait_stop(1'b0, 1'b0);
    event_rise(1'b0, 1'b0);
    rd_reg(2'h0);
    wr_reg(2'h0, 8'h00);
    rd_reg(2'h0);
    wr_reg(2'h1, 8'h20);
    event_rise(1'b1, 1'b0);
    event_rise(1'b1, 1'b1);
    rd_reg(2'h0);
    rd_reg(2'h1);
    wr_reg(2'h1, 8'h20);
    rd_reg(2'h0);
    end_of_test();
  end
endmodule
